// [rtl/evt_status_low.sv]
// Low nine bits of the event status word, its mask and interrupt output,
// plus the receive resource gating tied to the buffer exhausted flag.
// Assumes transmit, receive and counter logic run on CLK and give pulses.
`timescale 1ns/1ns
// How it works
// - Transmit packet error sets bit 8
// - Error causes written into descriptor status word
// - Timer wrap from zero to ones sets bit 7
// - List end marker seen sets bit 6
// - Read pointer meets write pointer sets bit 5
// - Bit 5 rises at last descriptor read
// - Reception halts until buffers added and cleared
// - Clearing bit 5 with buffers fetches descriptor
// - Buffer area end sets bit 4, aborts
// - Truncated packet: no reuse, no descriptor
// - Checksum tally wrap sets bit 3
// - Alignment tally wrap sets bit 2
// - Missed tally wrap sets bit 1
// - Receive FIFO overrun sets bit 0
// - FIFO underrun goes to transmit control
// - Writing one clears, zero leaves bit
// - Only unmasked bits drive interrupt output
// - Hardware reset clears, software reset keeps
module evt_status_low
  import evt_status_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SOFT_RESET,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Transmit events
  input wire logic TX_DONE,
  input wire logic TX_BYTE_COUNT_MISMATCH,
  input wire logic TX_EXCESS_COLLISIONS,
  input wire logic TX_FIFO_STARVED,
  input wire logic TX_EXCESS_DEFERRAL,
  output logic [3:0] TX_DESC_STATUS,
  output logic TX_DESC_STATUS_WE,
  output logic TX_CTRL_FIFO_STARVED,
  // Counters
  input wire logic [31:0] TIMER_COUNT,
  input wire logic [15:0] CHECKSUM_TALLY,
  input wire logic [15:0] ALIGN_TALLY,
  input wire logic [15:0] MISSED_TALLY,
  // Receive resource events
  input wire logic LIST_END_SEEN,
  input wire logic RESOURCE_LAST_FIELD_READ,
  input wire logic [PTR_W-1:0] RESOURCE_READ_PTR,
  input wire logic [PTR_W-1:0] RESOURCE_WRITE_PTR,
  input wire logic LAST_BUFFER_USED,
  input wire logic BUFFER_AREA_END,
  input wire logic RX_FIFO_FULL_NO_BUS,
  // Receive control
  output logic RX_ENABLE,
  output logic FETCH_RESOURCE,
  output logic RX_ABORT_PACKET,
  // Interrupt
  output logic INT_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic bus_req;
  logic wr_lo;
  logic [8:0] clr_bits;
  logic [8:0] set_bits;
  logic [8:0] status;
  logic [8:0] mask_reg;
  logic rx_halt_reg;
  logic fetch_cmd_reg;
  logic starved_reg;
  logic timer_wrap;
  logic checksum_wrap;
  logic align_wrap;
  logic missed_wrap;
  logic buf_clear;
  logic buffers_added;
  logic hit_status;
  logic hit_mask;
  logic hit_state;
  logic [31:0] rd_data_next;

  // A request is taken once, then ack drops for a cycle
  assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // Both low byte lanes must be enabled to touch the nine bits
  assign wr_lo = bus_req && WB_WE_I && WB_SEL_I[0] && WB_SEL_I[1];

  // One select per register; any other address is unmapped and reads zero
  always_comb begin
    hit_status = 1'b0;
    hit_mask = 1'b0;
    hit_state = 1'b0;
    if (WB_ADR_I == STATUS_OFS) begin
      hit_status = 1'b1;
    end else if (WB_ADR_I == MASK_OFS) begin
      hit_mask = 1'b1;
    end else if (WB_ADR_I == STATE_OFS) begin
      hit_state = 1'b1;
    end
  end

  // Read word picked ahead of the answer edge; the data flop only loads it
  always_comb begin
    rd_data_next = UNMAPPED_READ;
    if (hit_status) begin
      rd_data_next = {23'h000000, status};
    end else if (hit_mask) begin
      rd_data_next = {23'h000000, mask_reg};
    end else if (hit_state) begin
      rd_data_next = {30'h00000000, fetch_cmd_reg, rx_halt_reg};
    end
  end

  // Write-one clear strobes on the status word
  // A strobe lasts one cycle only, because the request is taken once
  always_comb begin
    clr_bits = 9'h000;
    if (wr_lo && hit_status) begin
      clr_bits = WB_DAT_I[8:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event sources

  wrap_detect #(.W(32), .FROM_VAL(TIMER_ZERO), .TO_VAL(~TIMER_ZERO)) u_timer_wrap (
    .clk(CLK),
    .srst(SRST),
    .count(TIMER_COUNT),
    .wrapped(timer_wrap)
  );
  wrap_detect #(.W(16), .FROM_VAL(TALLY_ONES), .TO_VAL(~TALLY_ONES)) u_checksum_wrap (
    .clk(CLK),
    .srst(SRST),
    .count(CHECKSUM_TALLY),
    .wrapped(checksum_wrap)
  );
  wrap_detect #(.W(16), .FROM_VAL(TALLY_ONES), .TO_VAL(~TALLY_ONES)) u_align_wrap (
    .clk(CLK),
    .srst(SRST),
    .count(ALIGN_TALLY),
    .wrapped(align_wrap)
  );
  wrap_detect #(.W(16), .FROM_VAL(TALLY_ONES), .TO_VAL(~TALLY_ONES)) u_missed_wrap (
    .clk(CLK),
    .srst(SRST),
    .count(MISSED_TALLY),
    .wrapped(missed_wrap)
  );

  // Gather the set pulses; underrun alone still counts as transmit error
  always_comb begin
    set_bits = 9'h000;
    set_bits[SEND_FAULT_BIT] = TX_DONE && (TX_BYTE_COUNT_MISMATCH ||
      TX_EXCESS_COLLISIONS || TX_FIFO_STARVED || TX_EXCESS_DEFERRAL);
    set_bits[TIMER_WRAP_BIT] = timer_wrap;
    set_bits[DESC_USED_UP_BIT] = LIST_END_SEEN;
    // Early warning: flagged when the last descriptor is read
    set_bits[BUF_USED_UP_BIT] = RESOURCE_LAST_FIELD_READ &&
      (RESOURCE_READ_PTR == RESOURCE_WRITE_PTR);
    set_bits[AREA_OVERFLOW_BIT] = BUFFER_AREA_END;
    set_bits[CHECKSUM_WRAP_BIT] = checksum_wrap;
    set_bits[ALIGN_WRAP_BIT] = align_wrap;
    set_bits[MISSED_WRAP_BIT] = missed_wrap;
    set_bits[RX_FIFO_OVF_BIT] = RX_FIFO_FULL_NO_BUS;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  // Of the two resets only SRST clears the flags; SOFT_RESET is deliberately not wired
  generate
    for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
      w1c_flag u_flag (
        .clk(CLK),
        .srst(SRST),
        .set_evt(set_bits[i]),
        .clr_evt(clr_bits[i]),
        .flag(status[i])
      );
    end
  endgenerate

  // Mask register, low byte lanes only
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mask_reg <= MASK_RESET;
    end else if (wr_lo && hit_mask) begin
      mask_reg <= WB_DAT_I[8:0];
    end
  end

  // Interrupt from unmasked flags, registered
  // Costs one cycle of latency but keeps the pin free of decode glitches
  always_ff @(posedge CLK) begin
    if (SRST) begin
      INT_OUT <= 1'b0;
    end else begin
      INT_OUT <= |(status & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit error reporting

  // Causes go to the descriptor; underrun also goes to transmit control
  always_ff @(posedge CLK) begin
    if (SRST) begin
      TX_DESC_STATUS <= 4'h0;
      TX_DESC_STATUS_WE <= 1'b0;
      starved_reg <= 1'b0;
    end else begin
      TX_DESC_STATUS_WE <= TX_DONE;
      if (TX_DONE) begin
        TX_DESC_STATUS[CAUSE_MISMATCH_BIT] <= TX_BYTE_COUNT_MISMATCH;
        TX_DESC_STATUS[CAUSE_COLLISION_BIT] <= TX_EXCESS_COLLISIONS;
        TX_DESC_STATUS[CAUSE_FIFO_BIT] <= TX_FIFO_STARVED;
        TX_DESC_STATUS[CAUSE_DEFERRAL_BIT] <= TX_EXCESS_DEFERRAL;
        starved_reg <= TX_FIFO_STARVED;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      TX_CTRL_FIFO_STARVED <= 1'b0;
    end else begin
      TX_CTRL_FIFO_STARVED <= starved_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive gating

  // Software is trusted to add descriptors before clearing
  assign buffers_added = (RESOURCE_WRITE_PTR != RESOURCE_READ_PTR);
  assign buf_clear = clr_bits[BUF_USED_UP_BIT] && status[BUF_USED_UP_BIT] &&
    !set_bits[BUF_USED_UP_BIT];

  // Halt after the last buffer; resume when cleared with buffers added
  // Halt is armed only while bit 5 is set, so a last-buffer pulse with
  // resources still queued cannot stop reception
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rx_halt_reg <= 1'b0;
    end else if (LAST_BUFFER_USED && status[BUF_USED_UP_BIT]) begin
      rx_halt_reg <= 1'b1;
    end else if (rx_halt_reg && !status[BUF_USED_UP_BIT] && buffers_added) begin
      rx_halt_reg <= 1'b0;
    end
  end

  // Descriptor fetch on clear with buffers, or on area overflow
  always_ff @(posedge CLK) begin
    if (SRST) begin
      fetch_cmd_reg <= 1'b0;
    end else begin
      fetch_cmd_reg <= (buf_clear && buffers_added) || BUFFER_AREA_END;
    end
  end

  // Outputs of the receive gating, all from flops
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RX_ENABLE <= 1'b1;
      FETCH_RESOURCE <= 1'b0;
      RX_ABORT_PACKET <= 1'b0;
    end else begin
      RX_ENABLE <= !rx_halt_reg;
      FETCH_RESOURCE <= fetch_cmd_reg;
      // Abort drops the rest of the area and skips the descriptor write
      RX_ABORT_PACKET <= BUFFER_AREA_END;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer

  // One wait-free cycle: ack and data the edge after the request is seen
  // Data loads only on reads, so it stands until the next read answer
  always_ff @(posedge CLK) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= UNMAPPED_READ;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_req && !WB_WE_I) begin
        WB_DAT_O <= rd_data_next;
      end
    end
  end

endmodule // evt_status_low

// [shared/evt_status_pkg.sv]
// Package for the low event status block: register offsets, bit positions,
// reset values and the bus answer constants.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package evt_status_pkg;
  // Register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] CONTROL_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0C;
  // Bit positions in the status word
  localparam int SEND_FAULT_BIT = 8;
  localparam int TIMER_WRAP_BIT = 7;
  localparam int DESC_USED_UP_BIT = 6;
  localparam int BUF_USED_UP_BIT = 5;
  localparam int AREA_OVERFLOW_BIT = 4;
  localparam int CHECKSUM_WRAP_BIT = 3;
  localparam int ALIGN_WRAP_BIT = 2;
  localparam int MISSED_WRAP_BIT = 1;
  localparam int RX_FIFO_OVF_BIT = 0;
  localparam int FLAG_COUNT = 9;
  // Transmit error cause positions in the descriptor status word
  localparam int CAUSE_MISMATCH_BIT = 0;
  localparam int CAUSE_COLLISION_BIT = 1;
  localparam int CAUSE_FIFO_BIT = 2;
  localparam int CAUSE_DEFERRAL_BIT = 3;
  // Reset values
  localparam logic [8:0] STATUS_RESET = 9'h000;
  localparam logic [8:0] MASK_RESET = 9'h000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // Counter wrap patterns
  localparam logic [31:0] TIMER_ZERO = 32'h0000_0000;
  localparam logic [15:0] TALLY_ONES = 16'hFFFF;
  // Pointer width
  localparam int PTR_W = 16;
endpackage

// [rtl/wrap_detect.sv]
// Detects a counter stepping from one fixed value to another.
// Assumes the counter is sampled on the same clock as the block.
`timescale 1ns/1ns
module wrap_detect #(
  parameter int W = 16,
  parameter logic [W-1:0] FROM_VAL = '1,
  parameter logic [W-1:0] TO_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Counter and event
  input wire logic [W-1:0] count,
  output logic wrapped
);
  logic [W-1:0] last_reg;
  logic primed_reg;

  // Remember the last value; first sample after reset cannot count as wrap
  always_ff @(posedge clk) begin
    if (srst) begin
      last_reg <= '0;
      primed_reg <= 1'b0;
    end else begin
      last_reg <= count;
      primed_reg <= 1'b1;
    end
  end

  assign wrapped = primed_reg && (last_reg == FROM_VAL) && (count == TO_VAL);
endmodule // wrap_detect

// [rtl/w1c_flag.sv]
// One sticky status flag: set by hardware, cleared by a write of one.
// Assumes the clear strobe lasts one cycle.
`timescale 1ns/1ns
module w1c_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Set and clear
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag
);
  // Set wins over clear so an event in the clear cycle survives
  always_ff @(posedge clk) begin
    if (srst) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_evt) begin
      flag <= 1'b0;
    end
  end
endmodule // w1c_flag

// [verification/evt_status_low_sva.sv]
// Checker for the low event status block, bound to its top module ports.
// Assumes one clock domain with a synchronous active high reset.
`timescale 1ns/1ns
module evt_status_low_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // Transmit and receive
  input wire logic TX_DONE,
  input wire logic TX_FIFO_STARVED,
  input wire logic TX_DESC_STATUS_WE,
  input wire logic TX_CTRL_FIFO_STARVED,
  input wire logic BUFFER_AREA_END,
  input wire logic LAST_BUFFER_USED,
  input wire logic RX_ABORT_PACKET,
  input wire logic FETCH_RESOURCE,
  input wire logic RX_ENABLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////
  // Bus answer timing: one pulse, one cycle after the request is taken
  property p_ack_rise; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("no ack");
  property p_ack_drop; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
  // Descriptor status write follows each finished packet, and only then
  property p_desc_we; TX_DONE |=> TX_DESC_STATUS_WE; endproperty
  a_desc_we: assert property (p_desc_we) else $error("no descriptor write");
  property p_desc_only; TX_DESC_STATUS_WE |-> $past(TX_DONE); endproperty
  a_desc_only: assert property (p_desc_only) else $error("stray descriptor");
  // Underrun lands in the transmit control view two cycles on
  property p_starve; TX_DONE |-> ##2 TX_CTRL_FIFO_STARVED == $past(TX_FIFO_STARVED, 2); endproperty
  a_starve: assert property (p_starve) else $error("underrun lost");
  // Area overflow aborts the packet, then fetches new resources
  property p_abort; BUFFER_AREA_END |=> RX_ABORT_PACKET; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_area_fetch; BUFFER_AREA_END |-> ##2 FETCH_RESOURCE; endproperty
  a_area_fetch: assert property (p_area_fetch) else $error("no fetch");
  // Reception only stops because the last buffer went
  property p_halt; $fell(RX_ENABLE) |-> $past(LAST_BUFFER_USED, 2); endproperty
  a_halt: assert property (p_halt) else $error("stray halt");
  ////////////////////////////////////////
  // Main scenarios reached
  c_halt: cover property ($fell(RX_ENABLE));
  c_fetch: cover property (FETCH_RESOURCE && !$past(BUFFER_AREA_END, 2));
  c_tx: cover property (TX_DONE);
endmodule // evt_status_low_sva
bind evt_status_low evt_status_low_sva evt_status_low_sva_inst (.CLK(CLK), .SRST(SRST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .TX_DONE(TX_DONE),
  .TX_FIFO_STARVED(TX_FIFO_STARVED), .TX_DESC_STATUS_WE(TX_DESC_STATUS_WE),
  .TX_CTRL_FIFO_STARVED(TX_CTRL_FIFO_STARVED), .BUFFER_AREA_END(BUFFER_AREA_END),
  .LAST_BUFFER_USED(LAST_BUFFER_USED), .RX_ABORT_PACKET(RX_ABORT_PACKET),
  .FETCH_RESOURCE(FETCH_RESOURCE), .RX_ENABLE(RX_ENABLE));

// [verification/evt_status_low_tb_top.sv]
// Bench for the low event status block: bus access, event flags, receive gating.
// Assumes the block answers a bus request one cycle after taking it.
`timescale 1ns/1ns
module evt_status_low_tb_top;
  import evt_status_pkg::*;
  logic CLK = '0, SRST = '1, SOFT_RESET = '0, WB_CYC_I = '0, WB_STB_I = '0, WB_WE_I = '0;
  logic [7:0] WB_ADR_I = '0;
  logic [3:0] WB_SEL_I = '0, cause = '0, TX_DESC_STATUS;
  logic [31:0] WB_DAT_I = '0, WB_DAT_O, TIMER_COUNT = '0;
  logic [15:0] CHECKSUM_TALLY = '1, ALIGN_TALLY = '1, MISSED_TALLY = '1;
  logic [PTR_W-1:0] rd_ptr = '0, wr_ptr = '0;
  logic [5:0] ev = '0; // Fifo full, area end, list end, last field, last buffer, tx done
  logic WB_ACK_O, TX_DESC_STATUS_WE, RX_ENABLE, FETCH_RESOURCE, INT_OUT;
  logic [31:0] rd_q[$];
  logic [3:0] tx_q[$];
  int num_errors = 0, tests_run = 0, fetches = 0, n;
  evt_status_low evt_status_low_inst (.CLK(CLK), .SRST(SRST), .SOFT_RESET(SOFT_RESET),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .TX_DONE(ev[5]), .TX_BYTE_COUNT_MISMATCH(cause[0]), .TX_EXCESS_COLLISIONS(cause[1]),
    .TX_FIFO_STARVED(cause[2]), .TX_EXCESS_DEFERRAL(cause[3]),
    .TX_DESC_STATUS(TX_DESC_STATUS), .TX_DESC_STATUS_WE(TX_DESC_STATUS_WE),
    .TX_CTRL_FIFO_STARVED(), .TIMER_COUNT(TIMER_COUNT), .CHECKSUM_TALLY(CHECKSUM_TALLY),
    .ALIGN_TALLY(ALIGN_TALLY), .MISSED_TALLY(MISSED_TALLY), .LIST_END_SEEN(ev[2]),
    .RESOURCE_LAST_FIELD_READ(ev[3]), .RESOURCE_READ_PTR(rd_ptr),
    .RESOURCE_WRITE_PTR(wr_ptr), .LAST_BUFFER_USED(ev[4]), .BUFFER_AREA_END(ev[1]),
    .RX_FIFO_FULL_NO_BUS(ev[0]), .RX_ENABLE(RX_ENABLE), .FETCH_RESOURCE(FETCH_RESOURCE),
    .RX_ABORT_PACKET(), .INT_OUT(INT_OUT));
  ////////////////////////////////////////
  // Clock at 50 ns
  always #25 CLK = ~CLK;
  task automatic fail(input string m);
    $display("unexpected at %0t: %s", $time, m);
    num_errors++;
  endtask
  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) fail("word differs");
  endtask
  task automatic chk_bit(input logic e, input logic g);
    tests_run++;
    if (g !== e) fail("level differs");
  endtask
  task automatic test_done;
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One classic cycle; request held until the ack edge, then dropped
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    WB_CYC_I <= 1'h1;
    WB_STB_I <= 1'h1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_SEL_I <= s;
    WB_DAT_I <= d;
    do begin
      @(posedge CLK);
      k++;
    end while (WB_ACK_O !== 1'h1 && k < 20);
    WB_CYC_I <= 1'h0;
    WB_STB_I <= 1'h0;
    if (k >= 20) begin
      fail("no ack");
      test_done();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'h0, a, 4'hF, 32'h0);
  endtask
  // Raises one status source; counters idle at values that never wrap
  task automatic fire(input int i, input logic [3:0] c);
    @(posedge CLK);
    case (i)
      1: MISSED_TALLY <= '0;
      2: ALIGN_TALLY <= '0;
      3: CHECKSUM_TALLY <= '0;
      7: TIMER_COUNT <= '1;
      9: ev <= 6'h10;
      8: begin
        ev <= 6'h20;
        cause <= c;
        tx_q.push_back(c);
      end
      default: ev <= (i == 0) ? 6'h01 : (i == 4) ? 6'h02 : (i == 6) ? 6'h04 : 6'h08;
    endcase
    @(posedge CLK);
    ev <= '0;
    cause <= '0;
  endtask
  // Takes the oldest note whenever a read answer or a descriptor write appears
  always @(posedge CLK) begin
    if (WB_ACK_O === 1'h1 && WB_WE_I === 1'h0)
      chk_word(rd_q.pop_front(), WB_DAT_O);
    if (TX_DESC_STATUS_WE === 1'h1)
      chk_word({28'h0, tx_q.pop_front()}, {28'h0, TX_DESC_STATUS});
    if (FETCH_RESOURCE === 1'h1)
      fetches++;
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge CLK);
    fail("run too long");
    test_done();
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(20));
    repeat (10) @(posedge CLK);
    SRST <= 1'h0;
    rd(STATUS_OFS, 32'h0);
    rd(MASK_OFS, 32'h0);
    rd(CONTROL_OFS, 32'h0);
    rd(8'h10, 32'h0);
    rd(STATE_OFS, 32'h0);
    chk_bit(1'h1, RX_ENABLE);
    $display("done: reset values");
    wb(1'h1, MASK_OFS, 4'hF, 32'h1FF);
    for (int i = 0; i < FLAG_COUNT; i++) begin
      if (i == BUF_USED_UP_BIT)
        continue;
      fire(i, 4'($urandom_range(1, 15)));
      rd(STATUS_OFS, 32'h1 << i);
      chk_bit(1'h1, INT_OUT);
      wb(1'h1, STATUS_OFS, 4'h1, 32'h1 << i);
      wb(1'h1, STATUS_OFS, 4'hF, 32'h0);
      rd(STATUS_OFS, 32'h1 << i);
      wb(1'h1, STATUS_OFS, 4'hF, 32'h1 << i);
      rd(STATUS_OFS, 32'h0);
      chk_bit(1'h0, INT_OUT);
      CHECKSUM_TALLY <= '1;
      ALIGN_TALLY <= '1;
      MISSED_TALLY <= '1;
      TIMER_COUNT <= '0;
    end
    fire(8, 4'h0);
    rd(STATUS_OFS, 32'h0);
    $display("done: flags");
    // Clear and fresh event in the same cycles
    fire(0, 4'h0);
    fork
      wb(1'h1, STATUS_OFS, 4'hF, 32'h1);
      begin
        @(posedge CLK);
        ev <= 6'h01;
        @(posedge CLK);
        ev <= 6'h00;
      end
    join
    rd(STATUS_OFS, 32'h1);
    wb(1'h1, STATUS_OFS, 4'hF, 32'h1);
    $display("done: set over clear");
    wr_ptr <= 16'h0006;
    rd_ptr <= 16'h0005;
    fire(5, 4'h0);
    rd(STATUS_OFS, 32'h0);
    wr_ptr <= 16'h0005;
    fire(5, 4'h0);
    rd(STATUS_OFS, 32'h20);
    fire(9, 4'h0); // Last buffer used while bit 5 is set
    repeat (3) @(posedge CLK);
    chk_bit(1'h0, RX_ENABLE);
    n = fetches;
    wr_ptr <= 16'h0007; // Buffers added before clearing
    wb(1'h1, STATUS_OFS, 4'hF, 32'h20);
    repeat (4) @(posedge CLK);
    chk_word(32'(n + 1), 32'(fetches));
    chk_bit(1'h1, RX_ENABLE);
    $display("done: buffer exhaustion");
    wb(1'h1, MASK_OFS, 4'hF, 32'h0);
    fire(0, 4'h0);
    repeat (3) @(posedge CLK);
    chk_bit(1'h0, INT_OUT);
    SOFT_RESET <= 1'h1;
    repeat (2) @(posedge CLK);
    SOFT_RESET <= 1'h0;
    rd(STATUS_OFS, 32'h1);
    SRST <= 1'h1;
    repeat (2) @(posedge CLK);
    SRST <= 1'h0;
    rd(STATUS_OFS, 32'h0);
    $display("done: resets");
    test_done();
  end
endmodule // evt_status_low_tb_top
